// ===== hdl/rdi_insert_pkg.sv
// Purpose: shared constants and carriers for path rdi auto insertion
// Assumes: 8-bit register port, sonet bit 1 is the msb of a byte
// Notes: rdi field sits in g1 bits 3..1 counted from lsb
package rdi_insert_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] PATH_CTRL0_ADDR = 16'h1983;
  localparam logic [15:0] RDI_CTRL1_ADDR = 16'h19ca;
  localparam logic [15:0] RDI_CTRL0_ADDR = 16'h19cb;
  localparam logic [15:0] RDI_STATUS_ADDR = 16'h19cf;

  localparam logic [7:0] PATH_CTRL0_RESET = 8'h00;
  localparam logic [7:0] RDI_CTRL1_RESET = 8'h00;
  localparam logic [7:0] RDI_CTRL0_RESET = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int INSERT_SEL_LSB = 3;
  localparam int G1_RDI_LSB = 1;
  localparam logic [1:0] INSERT_SEL_AUTO = 2'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ais;
    logic lop;
    logic uneq;
    logic tim;
  } defect_set_t;

  typedef struct packed {
    logic [2:0] pointer_loss_defect_code;
    logic pointer_loss_trigger_en;
    logic [2:0] path_alarm_defect_code;
    logic path_alarm_trigger_en;
  } rdi_ctrl0_t;

  typedef struct packed {
    logic [2:0] trace_mismatch_defect_code;
    logic trace_mismatch_trigger_en;
    logic [2:0] unequipped_defect_code;
    logic unequipped_trigger_en;
  } rdi_ctrl1_t;

endpackage

// ===== hdl/rdi_code_select.sv
// Purpose: pick one rdi code from the enabled, declared defects
// Assumes: defects already registered by the caller
// Notes: fixed priority ais, pointer loss, unequipped, trace mismatch
`timescale 1ns/1ps
module rdi_code_select (
  // defects from the paired receiver
  input wire rdi_insert_pkg::defect_set_t defects,
  // control fields
  input wire rdi_insert_pkg::rdi_ctrl0_t ctrl0,
  input wire rdi_insert_pkg::rdi_ctrl1_t ctrl1,
  // selected code
  output logic [2:0] code,
  output logic hit
);

  always_comb begin
    code = 3'h0;
    hit = 1'b0;
    if (defects.ais && ctrl0.path_alarm_trigger_en) begin
      code = ctrl0.path_alarm_defect_code;
      hit = 1'b1;
    end else if (defects.lop && ctrl0.pointer_loss_trigger_en) begin
      code = ctrl0.pointer_loss_defect_code;
      hit = 1'b1;
    end else if (defects.uneq && ctrl1.unequipped_trigger_en) begin
      code = ctrl1.unequipped_defect_code;
      hit = 1'b1;
    end else if (defects.tim && ctrl1.trace_mismatch_trigger_en) begin
      code = ctrl1.trace_mismatch_defect_code;
      hit = 1'b1;
    end
  end

endmodule

// ===== hdl/path_rdi_auto_insert.sv
// Purpose: automatic path rdi insertion into the outbound g1 byte
// Assumes: g1_valid marks the g1 slot of the transmit frame stream
// Notes: other insertion modes pass g1 through unchanged
//
// Summary of operation
// - unequipped code is read/write in bits 3..1 of control byte 1.
// - control byte 1 bit 0 enables rdi on unequipped.
// - enabled declared unequipped puts its code into outbound g1 rdi bits unless enabled declared path alarm or pointer loss also triggers.
// - pointer loss code is read/write in bits 7..5 of control byte 0.
// - control byte 0 bit 4 enables rdi on pointer loss.
// - enabled declared pointer loss puts its code into outbound g1 rdi bits unless enabled declared path alarm also triggers.
// - path alarm code is read/write in bits 3..1 of control byte 0.
// - control byte 0 bit 0 enables rdi on path alarm.
// - enabled declared path alarm puts its code into outbound g1 rdi bits.
// - trace mismatch code is read/write in bits 7..5 of control byte 1.
// - triggers come only from the paired receive path processor.
// - control byte 1 bit 4 enables rdi on trace mismatch.
// - automatic insertion only while the insertion select field is zero.
// - chosen code goes into g1 bits 5 to 7, sonet numbering.
`timescale 1ns/1ps
module path_rdi_auto_insert #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // defects from the paired receive path processor
  input wire rdi_insert_pkg::defect_set_t rx_defects,
  // transmit g1 stream
  input wire logic g1_valid,
  input wire logic [7:0] g1_in,
  output logic g1_out_valid,
  output logic [7:0] g1_out
);

  // ****************************************
  // elaboration check
  // ****************************************
  generate
    if (ADDR_W < 16) begin : g_bad_addr
      $error("ADDR_W must be at least 16");
    end
  endgenerate

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] path_ctrl0_reg;
  rdi_insert_pkg::rdi_ctrl0_t path_rdi_control_pointer_ais_reg;
  rdi_insert_pkg::rdi_ctrl1_t path_rdi_control_trace_unequipped_reg;
  rdi_insert_pkg::defect_set_t defects_reg;
  logic [7:0] status_reg;
  logic [1:0] remote_defect_insert_select;
  logic [2:0] sel_code;
  logic sel_hit;
  logic wr_en;
  logic rd_en;

  assign wr_en = reg_cs && reg_wr;
  assign rd_en = reg_cs && reg_rd;
  assign remote_defect_insert_select = path_ctrl0_reg[rdi_insert_pkg::INSERT_SEL_LSB +: 2];

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [15:0] ref_a);
    addr_is = (a == ADDR_W'(ref_a));
  endfunction

  function automatic logic sel_is_auto(input logic [1:0] s);
    sel_is_auto = (s == rdi_insert_pkg::INSERT_SEL_AUTO);
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      path_ctrl0_reg <= rdi_insert_pkg::PATH_CTRL0_RESET;
    end else if (wr_en && addr_is(reg_addr, rdi_insert_pkg::PATH_CTRL0_ADDR)) begin
      path_ctrl0_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      path_rdi_control_pointer_ais_reg <= rdi_insert_pkg::RDI_CTRL0_RESET;
    end else if (wr_en && addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL0_ADDR)) begin
      path_rdi_control_pointer_ais_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      path_rdi_control_trace_unequipped_reg <= rdi_insert_pkg::RDI_CTRL1_RESET;
    end else if (wr_en && addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL1_ADDR)) begin
      path_rdi_control_trace_unequipped_reg <= reg_wdata;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= rd_en;
      if (rd_en) begin
        if (addr_is(reg_addr, rdi_insert_pkg::PATH_CTRL0_ADDR)) begin
          reg_rdata <= path_ctrl0_reg;
        end else if (addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL0_ADDR)) begin
          reg_rdata <= path_rdi_control_pointer_ais_reg;
        end else if (addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL1_ADDR)) begin
          reg_rdata <= path_rdi_control_trace_unequipped_reg;
        end else if (addr_is(reg_addr, rdi_insert_pkg::RDI_STATUS_ADDR)) begin
          reg_rdata <= status_reg;
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

  // ****************************************
  // defect capture and code selection
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      defects_reg <= '0;
    end else begin
      defects_reg <= rx_defects;
    end
  end

  rdi_code_select u_select (
    .defects(defects_reg),
    .ctrl0(path_rdi_control_pointer_ais_reg),
    .ctrl1(path_rdi_control_trace_unequipped_reg),
    .code(sel_code),
    .hit(sel_hit)
  );

  // status: hit, code, captured defects
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= {sel_hit, sel_code, defects_reg};
    end
  end

  // ****************************************
  // g1 insertion
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      g1_out <= 8'h00;
      g1_out_valid <= 1'b0;
    end else begin
      g1_out_valid <= g1_valid;
      if (g1_valid) begin
        if (sel_is_auto(remote_defect_insert_select)) begin
          g1_out <= {g1_in[7:4], sel_code, g1_in[0]};
        end else begin
          g1_out <= g1_in;
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic auto_mode;
  assign auto_mode = sel_is_auto(remote_defect_insert_select);

  sequence s_auto_slot;
    g1_valid && auto_mode;
  endsequence

  sequence s_wr(logic [15:0] a);
    wr_en && addr_is(reg_addr, a);
  endsequence

  chk_uneq_code_out: assert property (
    s_auto_slot and (defects_reg.uneq && path_rdi_control_trace_unequipped_reg[0]
    && !(defects_reg.ais && path_rdi_control_pointer_ais_reg[0])
    && !(defects_reg.lop && path_rdi_control_pointer_ais_reg[4]))
    |=> g1_out[3:1] == $past(path_rdi_control_trace_unequipped_reg[3:1]))
    else $error("unequipped code not inserted");

  chk_lop_code_out: assert property (
    s_auto_slot and (defects_reg.lop && path_rdi_control_pointer_ais_reg[4]
    && !(defects_reg.ais && path_rdi_control_pointer_ais_reg[0]))
    |=> g1_out[3:1] == $past(path_rdi_control_pointer_ais_reg[7:5]))
    else $error("pointer loss code not inserted");

  chk_ais_code_out: assert property (
    s_auto_slot and (defects_reg.ais && path_rdi_control_pointer_ais_reg[0])
    |=> g1_out[3:1] == $past(path_rdi_control_pointer_ais_reg[3:1]))
    else $error("path alarm code not inserted");

  chk_tim_code_out: assert property (
    s_auto_slot and (defects_reg == 4'h1 && path_rdi_control_trace_unequipped_reg[4])
    |=> g1_out[3:1] == $past(path_rdi_control_trace_unequipped_reg[7:5]))
    else $error("trace mismatch code not inserted");

  chk_idle_zero_code: assert property (
    s_auto_slot and (defects_reg == 4'h0) |=> g1_out[3:1] == 3'h0)
    else $error("rdi code not zero without defects");

  chk_ais_disabled: assert property (
    s_auto_slot and (defects_reg == 4'h8 && !path_rdi_control_pointer_ais_reg[0])
    |=> g1_out[3:1] == 3'h0)
    else $error("disabled path alarm drove rdi");

  chk_mode_gates: assert property (
    g1_valid && !auto_mode |=> g1_out == $past(g1_in) && g1_out_valid)
    else $error("g1 altered outside automatic mode");

  chk_g1_bits_kept: assert property (
    s_auto_slot |=> g1_out[7:4] == $past(g1_in[7:4]) && g1_out[0] == $past(g1_in[0]))
    else $error("g1 bits outside rdi field changed");

  chk_ctrl1_readback: assert property (
    s_wr(rdi_insert_pkg::RDI_CTRL1_ADDR) ##1
    (rd_en && !wr_en && addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL1_ADDR))
    |=> reg_rdata_valid && reg_rdata == $past(reg_wdata, 2))
    else $error("control byte 1 readback wrong");

  chk_ctrl0_readback: assert property (
    s_wr(rdi_insert_pkg::RDI_CTRL0_ADDR) ##1
    (rd_en && !wr_en && addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL0_ADDR))
    |=> reg_rdata_valid && reg_rdata == $past(reg_wdata, 2))
    else $error("control byte 0 readback wrong");

  chk_defect_path: assert property (
    (rx_defects == 4'h0) ##1 s_auto_slot
    |=> g1_out[3:1] == 3'h0)
    else $error("rdi driven without receiver defect");

  // ****************************************
  // disabled triggers, register and hold checks
  // ****************************************
  sequence s_lone_defect(logic [3:0] d);
    s_auto_slot and (defects_reg == d);
  endsequence

  chk_uneq_disabled: assert property (
    s_lone_defect(4'h2) and (!path_rdi_control_trace_unequipped_reg[0])
    |=> g1_out[3:1] == 3'h0)
    else $error("disabled unequipped drove rdi");

  chk_lop_disabled: assert property (
    s_lone_defect(4'h4) and (!path_rdi_control_pointer_ais_reg[4])
    |=> g1_out[3:1] == 3'h0)
    else $error("disabled pointer loss drove rdi");

  chk_tim_disabled: assert property (
    s_lone_defect(4'h1) and (!path_rdi_control_trace_unequipped_reg[4])
    |=> g1_out[3:1] == 3'h0)
    else $error("disabled trace mismatch drove rdi");

  chk_ctrl0_write: assert property (
    s_wr(rdi_insert_pkg::RDI_CTRL0_ADDR)
    |=> path_rdi_control_pointer_ais_reg == $past(reg_wdata))
    else $error("control byte 0 write lost");

  chk_ctrl1_write: assert property (
    s_wr(rdi_insert_pkg::RDI_CTRL1_ADDR)
    |=> path_rdi_control_trace_unequipped_reg == $past(reg_wdata))
    else $error("control byte 1 write lost");

  chk_select_write: assert property (
    s_wr(rdi_insert_pkg::PATH_CTRL0_ADDR) |=> path_ctrl0_reg == $past(reg_wdata))
    else $error("path control write lost");

  chk_stray_write: assert property (
    wr_en && !addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL0_ADDR)
    && !addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL1_ADDR)
    |=> $stable(path_rdi_control_pointer_ais_reg)
    && $stable(path_rdi_control_trace_unequipped_reg))
    else $error("control byte changed by other write");

  chk_unmapped_read: assert property (
    rd_en && !addr_is(reg_addr, rdi_insert_pkg::PATH_CTRL0_ADDR)
    && !addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL0_ADDR)
    && !addr_is(reg_addr, rdi_insert_pkg::RDI_CTRL1_ADDR)
    && !addr_is(reg_addr, rdi_insert_pkg::RDI_STATUS_ADDR)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_rdata_pulse: assert property (
    1'b1 |=> reg_rdata_valid == $past(rd_en))
    else $error("read valid not one cycle after read");

  chk_rdata_holds: assert property (
    !rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  chk_g1_holds: assert property (
    !g1_valid |=> $stable(g1_out))
    else $error("g1 byte moved between slots");

  chk_out_valid_follows: assert property (
    1'b1 |=> g1_out_valid == $past(g1_valid))
    else $error("g1 valid not one cycle after slot");

endmodule

// ===== verif/remote_path_terminal.sv
// Purpose: far end path terminal that recovers the rdi field from g1
// Assumes: g1_out is stable while g1_out_valid is high
// Notes: sonet bits 5..7 of g1 are bits 3..1 counted from lsb
`timescale 1ns/1ps
module remote_path_terminal (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // outbound g1 stream
  input wire logic g1_out_valid,
  input wire logic [7:0] g1_out,
  // recovered indication
  output logic [2:0] rdi_seen,
  output logic seen_valid
);
  // ****************************************
  // capture of the received rdi code
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdi_seen <= 3'h0;
      seen_valid <= 1'b0;
    end else begin
      seen_valid <= g1_out_valid;
      if (g1_out_valid) begin
        rdi_seen <= g1_out[3:1];
      end
    end
  end
endmodule

// ===== verif/test_sts3c_path_rdi_auto_insert.sv
// Purpose: self-checking bench for automatic path rdi insertion
// Assumes: register and g1 timing as handed over by the designer
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module test_sts3c_path_rdi_auto_insert;
  logic core_clk, resetn, reg_cs, reg_wr, reg_rd, g1_valid, reg_rdata_valid, g1_out_valid;
  logic seen_valid;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, g1_in, g1_out, v, c0, c1, g;
  logic [2:0] rdi_seen;
  rdi_insert_pkg::defect_set_t rx_defects;
  int n_fail, comparisons;

  path_rdi_auto_insert #(.ADDR_W(16)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .rx_defects(rx_defects), .g1_valid(g1_valid), .g1_in(g1_in),
    .g1_out_valid(g1_out_valid), .g1_out(g1_out));
  remote_path_terminal i_far (.core_clk(core_clk), .resetn(resetn),
    .g1_out_valid(g1_out_valid), .g1_out(g1_out), .rdi_seen(rdi_seen), .seen_valid(seen_valid));

  // ****************************************
  // clock, shared tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_cs = 1'b0;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_cs = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    check("rdata_valid", {7'h0, reg_rdata_valid}, 8'h01);
    d = reg_rdata;
  endtask

  // write, then read the same address on the very next edge
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    check("rdata_valid", {7'h0, reg_rdata_valid}, 8'h01);
    q = reg_rdata;
  endtask

  // expected g1 byte from control bytes, select and defects ais,lop,uneq,tim
  function automatic logic [7:0] exp_g1(input logic [7:0] r0, r1, sel, input logic [3:0] d,
                                        input logic [7:0] gi);
    logic [2:0] code;
    code = 3'h0;
    if (sel[4:3] != 2'h0) return gi;
    if (d[0] && r1[4]) code = r1[7:5];
    if (d[1] && r1[0]) code = r1[3:1];
    if (d[2] && r0[4]) code = r0[7:5];
    if (d[3] && r0[0]) code = r0[3:1];
    return {gi[7:4], code, gi[0]};
  endfunction

  // one g1 slot: defects settle a cycle before the slot
  task automatic slot(input logic [3:0] d, input logic [7:0] gi, input logic [7:0] exp);
    @(negedge core_clk);
    rx_defects = d;
    @(negedge core_clk);
    g1_valid = 1'b1;
    g1_in = gi;
    @(negedge core_clk);
    g1_valid = 1'b0;
    check("g1_out_valid", {7'h0, g1_out_valid}, 8'h01);
    check("g1_out", g1_out, exp);
    @(negedge core_clk);
    check("far_rdi", {5'h0, rdi_seen}, {5'h0, exp[3:1]});
    check("far_valid", {7'h0, seen_valid}, 8'h01);
  endtask

  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    {reg_cs, reg_wr, reg_rd, g1_valid} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    g1_in = 8'h00;
    rx_defects = 4'h0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    rd(rdi_insert_pkg::RDI_CTRL1_ADDR, v);
    check("ctrl1_reset", v, rdi_insert_pkg::RDI_CTRL1_RESET);
    rd(rdi_insert_pkg::RDI_CTRL0_ADDR, v);
    check("ctrl0_reset", v, rdi_insert_pkg::RDI_CTRL0_RESET);
    rd(rdi_insert_pkg::PATH_CTRL0_ADDR, v);
    check("path_reset", v, rdi_insert_pkg::PATH_CTRL0_RESET);
    $display("test reset values done");
    wr_rd(rdi_insert_pkg::RDI_CTRL1_ADDR, 8'h5a, v);
    check("ctrl1_rw", v, 8'h5a);
    wr_rd(rdi_insert_pkg::RDI_CTRL0_ADDR, 8'ha5, v);
    check("ctrl0_rw", v, 8'ha5);
    wr(16'h1234, 8'hff);
    rd(16'h1234, v);
    check("unmapped", v, 8'h00);
    $display("test register access done");
    for (int k = 0; k < 3; k++) begin
      c0 = (k == 0) ? 8'hb7 : (k == 1) ? 8'hb6 : 8'ha3;
      c1 = (k == 0) ? 8'hd5 : (k == 1) ? 8'hc5 : 8'h7c;
      wr(rdi_insert_pkg::RDI_CTRL0_ADDR, c0);
      wr(rdi_insert_pkg::RDI_CTRL1_ADDR, c1);
      for (int d = 0; d < 16; d++) begin
        g = {d[3:0], 4'hf ^ d[3:0]};
        slot(d[3:0], g, exp_g1(c0, c1, 8'h00, d[3:0], g));
      end
    end
    $display("test defect priority done");
    for (int s = 1; s < 4; s++) begin
      wr(rdi_insert_pkg::PATH_CTRL0_ADDR, {3'h0, s[1:0], 3'h0});
      slot(4'hf, 8'h5a, 8'h5a);
    end
    rd(rdi_insert_pkg::RDI_STATUS_ADDR, v);
    check("status", v, {1'b1, c0[3:1], 4'hf});
    wr(rdi_insert_pkg::PATH_CTRL0_ADDR, 8'h00);
    slot(4'h8, 8'h5a, exp_g1(c0, c1, 8'h00, 4'h8, 8'h5a));
    $display("test insertion select done");
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
endmodule
